// [sam_pkg.sv]
// sam_pkg: constants, register map and state type of the setpoint alarm
// monitor; assumes a 250 MHz clock and 32-bit APB access.
// Behaviour
// [R1] A disabled alarm never trips and touches no output or record.
// [R2] Over alarm: pickup condition holds while value exceeds pickup setpoint.
// [R3] Under alarm: pickup condition holds while value is below pickup setpoint.
// [R4] Trip after pickup held for 0..999999 s; any break restarts count.
// [R5] Tripped over alarm: dropout condition holds while value below dropout.
// [R6] Alarm ends after dropout held 0..999999 s; under uses above dropout.
// [R7] Each alarm holds priority high, medium, low or none.
// [R8] Each alarm selects none, output one, output two or both to drive.
// [R9] In alarm mode the indicator LED blinks while an alarm is active.
// [R10] LED mode selects energy pulse or alarm; fixed variants ignore alarm.
// [R11] Active-alarm indication rises on trips of priority low, medium, high.
// [R12] High priority keeps the indication until that alarm is acknowledged.
// [R13] Each pickup enters the alarm into the readable active list.
// [R14] Keep history, per-alarm occurrence counts and unacknowledged set.
// [R15] Delays count a one-second tick; zero delay acts at once.
// [R16] Low and medium priority indication clears at dropout without ack.
package sam_pkg;
	localparam int SAM_NA   = 4;
	localparam int SAM_AIW  = 2;
	localparam int SAM_DW   = 32;
	localparam int SAM_DLYW = 20;
	localparam int SAM_OCCW = 16;
	localparam int SAM_AW   = 12;
	localparam logic [SAM_DLYW-1:0] SAM_DLY_MAX = 20'hF_423F;
	// one second at the clock rate
	localparam longint SAM_SEC_NS      = 1000000000;
	localparam longint SAM_CLK_NS      = 4;
	localparam int     SAM_TICK_CYCLES = int'(SAM_SEC_NS / SAM_CLK_NS);
	// global registers
	localparam logic [SAM_AW-1:0] SAM_A_STATUS  = 12'h000;
	localparam logic [SAM_AW-1:0] SAM_A_IRQ_CLR = 12'h004;
	localparam logic [SAM_AW-1:0] SAM_A_IRQ_EN  = 12'h008;
	localparam logic [SAM_AW-1:0] SAM_A_LED     = 12'h00C;
	localparam logic [SAM_AW-1:0] SAM_A_ACTIVE  = 12'h010;
	localparam logic [SAM_AW-1:0] SAM_A_UNACK   = 12'h014;
	localparam logic [SAM_AW-1:0] SAM_A_ACK     = 12'h018;
	localparam logic [SAM_AW-1:0] SAM_A_HIST    = 12'h01C;
	localparam logic [SAM_AW-1:0] SAM_A_SECONDS = 12'h020;
	// per-alarm block: base + index * 32
	localparam logic [SAM_AW-1:0] SAM_A_ALM_BASE = 12'h040;
	localparam int                SAM_A_STR_SH   = 5;
	localparam logic [4:0] SAM_S_CFG = 5'h00;
	localparam logic [4:0] SAM_S_PU  = 5'h04;
	localparam logic [4:0] SAM_S_DO  = 5'h08;
	localparam logic [4:0] SAM_S_PUD = 5'h0C;
	localparam logic [4:0] SAM_S_DOD = 5'h10;
	localparam logic [4:0] SAM_S_OCC = 5'h14;
	// configuration and history record fields
	localparam int SAM_CFG_EN    = 0;
	localparam int SAM_CFG_UNDER = 1;
	localparam int SAM_CFG_PRIO  = 2;
	localparam int SAM_CFG_DOUT  = 4;
	localparam int SAM_HIST_VAL  = 3;
	localparam int SAM_HIST_DROP = 2;
	localparam int SAM_HIST_SEC  = 8;

	typedef enum logic [1:0] {
		SAM_PRIO_NONE = 2'h0,
		SAM_PRIO_LOW  = 2'h1,
		SAM_PRIO_MED  = 2'h2,
		SAM_PRIO_HIGH = 2'h3
	} sam_prio_t;

	typedef struct packed {
		logic [SAM_NA-1:0]                en;
		logic [SAM_NA-1:0]                under;
		logic [SAM_NA-1:0][1:0]           prio;
		logic [SAM_NA-1:0][1:0]           dsel;
		logic [SAM_NA-1:0][SAM_DW-1:0]    pu;
		logic [SAM_NA-1:0][SAM_DW-1:0]    dr;
		logic [SAM_NA-1:0][SAM_DLYW-1:0]  pud;
		logic [SAM_NA-1:0][SAM_DLYW-1:0]  dod;
		logic [SAM_NA-1:0][SAM_DLYW-1:0]  cnt;
		logic [SAM_NA-1:0][SAM_OCCW-1:0]  occ;
		logic [SAM_NA-1:0]                active;
		logic [SAM_NA-1:0]                unack;
		logic [2*SAM_NA-1:0]              status;
		logic [2*SAM_NA-1:0]              irq_en;
		logic                             led_alarm;
		logic [SAM_DW-1:0]                hist;
		logic [SAM_DW-1:0]                secs;
		logic [SAM_DW-1:0]                div;
		logic                             blink;
		logic                             dout1;
		logic                             dout2;
		logic                             ind;
		logic                             led;
		logic                             irq;
		logic [SAM_DW-1:0]                prdata;
		logic                             pslverr;
	} sam_state_t;

	localparam sam_state_t SAM_STATE_RST = '0;
endpackage : sam_pkg

// [sam_top.sv]
// sam_top: setpoint alarm monitor with APB registers, one-second delay
// qualification, digital outputs, indicator LED and interrupt.
// VALUE_I and ENERGY_PULSE_I come from metering logic on CLK_I.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module sam_top
	import sam_pkg::*;
#(
	parameter int   TICK_CYCLES      = SAM_TICK_CYCLES,
	parameter logic LED_FIXED_ENERGY = 1'b0
) (
	// clock and reset
	input  wire logic                     CLK_I,
	input  wire logic                     RSTN_I,
	// apb slave
	input  wire logic                     PSEL_I,
	input  wire logic                     PENABLE_I,
	input  wire logic                     PWRITE_I,
	input  wire logic [SAM_AW-1:0]        PADDR_I,
	input  wire logic [SAM_DW-1:0]        PWDATA_I,
	output logic      [SAM_DW-1:0]        PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	// measurement
	input  wire logic [SAM_NA*SAM_DW-1:0] VALUE_I,
	input  wire logic                     ENERGY_PULSE_I,
	// alarm outputs
	output logic                          DIGITAL_OUTPUT_ONE_O,
	output logic                          DIGITAL_OUTPUT_TWO_O,
	output logic                          ALARM_ACTIVE_O,
	output logic                          LED_O,
	output logic                          IRQ_O
);
	sam_state_t              r_reg;
	sam_state_t              r_next;
	logic [SAM_NA-1:0]       pu_cond;
	logic [SAM_NA-1:0]       do_cond;
	logic [SAM_NA-1:0]       ev_pu;
	logic [SAM_NA-1:0]       ev_do;
	logic [SAM_NA-1:0]       set_ua;
	logic [SAM_NA-1:0]       sel1;
	logic [SAM_NA-1:0]       sel2;
	logic [SAM_NA-1:0]       p_nz;
	logic [SAM_NA-1:0]       p_hi;
	logic [SAM_AW-1:0]       aoff;
	logic [SAM_AIW-1:0]      ai;
	logic [4:0]              sub;
	logic                    in_alm;
	logic                    wr;
	logic                    tick;
	logic                    mapped;
	logic [SAM_DW-1:0]       rd;
	logic [SAM_DLYW-1:0]     wdly;

	// comparators, one set per alarm
	for (genvar g = 0; g < SAM_NA; g++) begin : g_cmp
		logic [SAM_DW-1:0] v;
		assign v = VALUE_I[g*SAM_DW +: SAM_DW];
		assign pu_cond[g] = r_reg.under[g] ? (v < r_reg.pu[g]) // [R3]
		                                   : (v > r_reg.pu[g]); // [R2]
		assign do_cond[g] = r_reg.under[g] ? (v > r_reg.dr[g]) // [R6]
		                                   : (v < r_reg.dr[g]); // [R5]
		assign sel1[g] = r_reg.dsel[g][0]; // [R8]
		assign sel2[g] = r_reg.dsel[g][1];
		assign p_nz[g] = r_reg.prio[g] != SAM_PRIO_NONE; // [R7]
		assign p_hi[g] = r_reg.prio[g] == SAM_PRIO_HIGH;
	end

	assign aoff   = PADDR_I - SAM_A_ALM_BASE;
	assign in_alm = (PADDR_I >= SAM_A_ALM_BASE) && (PADDR_I[1:0] == 2'h0)
	             && (int'(aoff >> SAM_A_STR_SH) < SAM_NA);
	assign ai     = aoff[SAM_A_STR_SH +: SAM_AIW];
	assign sub    = aoff[4:0];
	assign wr     = PSEL_I & PENABLE_I & PWRITE_I;
	assign tick   = r_reg.div == 32'(TICK_CYCLES - 1); // [R15]
	// out-of-range delays saturate at the largest legal setting
	assign wdly   = (PWDATA_I > 32'(SAM_DLY_MAX)) ? SAM_DLY_MAX
	                                               : PWDATA_I[SAM_DLYW-1:0];

	always_comb begin
		mapped = 1'b1;
		rd     = '0;
		if (in_alm) begin
			case (sub)
				SAM_S_CFG: rd = {26'h000_0000, r_reg.dsel[ai],
				                 r_reg.prio[ai], r_reg.under[ai],
				                 r_reg.en[ai]};
				SAM_S_PU:  rd = r_reg.pu[ai];
				SAM_S_DO:  rd = r_reg.dr[ai];
				SAM_S_PUD: rd = 32'(r_reg.pud[ai]);
				SAM_S_DOD: rd = 32'(r_reg.dod[ai]);
				SAM_S_OCC: rd = 32'(r_reg.occ[ai]); // [R14]
				default:   mapped = 1'b0;
			endcase
		end else begin
			case (PADDR_I)
				SAM_A_STATUS:  rd = 32'(r_reg.status);
				SAM_A_IRQ_CLR: rd = '0;
				SAM_A_IRQ_EN:  rd = 32'(r_reg.irq_en);
				SAM_A_LED:     rd = 32'(r_reg.led_alarm);
				SAM_A_ACTIVE:  rd = 32'(r_reg.active); // [R13]
				SAM_A_UNACK:   rd = 32'(r_reg.unack); // [R14]
				SAM_A_ACK:     rd = '0;
				SAM_A_HIST:    rd = r_reg.hist; // [R14]
				SAM_A_SECONDS: rd = r_reg.secs;
				default:       mapped = 1'b0;
			endcase
		end
	end

	always_comb begin
		r_next = r_reg;
		ev_pu  = '0;
		ev_do  = '0;
		set_ua = '0;
		r_next.div = tick ? '0 : r_reg.div + 32'h0000_0001;
		if (tick) begin
			r_next.secs = r_reg.secs + 32'h0000_0001;
		end
		if (tick || r_reg.div == 32'(TICK_CYCLES / 2 - 1)) begin
			r_next.blink = ~r_reg.blink;
		end
		// counts whole ticks, so a delay of n s resolves to n-1..n s
		for (int i = 0; i < SAM_NA; i++) begin
			if (!r_reg.en[i]) begin
				r_next.active[i] = 1'b0; // [R1]
				r_next.cnt[i]    = '0;
			end else if (!r_reg.active[i]) begin
				if (!pu_cond[i]) begin
					r_next.cnt[i] = '0; // [R4]
				end else if (r_reg.cnt[i] >= r_reg.pud[i]) begin
					r_next.active[i] = 1'b1; // [R4] [R15]
					r_next.cnt[i]    = '0;
					ev_pu[i]         = 1'b1;
				end else if (tick) begin
					r_next.cnt[i] = r_reg.cnt[i] + 20'h0_0001;
				end
			end else begin
				if (!do_cond[i]) begin
					r_next.cnt[i] = '0;
				end else if (r_reg.cnt[i] >= r_reg.dod[i]) begin
					r_next.active[i] = 1'b0; // [R6]
					r_next.cnt[i]    = '0;
					ev_do[i]         = 1'b1;
				end else if (tick) begin
					r_next.cnt[i] = r_reg.cnt[i] + 20'h0_0001;
				end
			end
			if (ev_pu[i]) begin
				if (r_reg.occ[i] != 16'hFFFF) begin
					r_next.occ[i] = r_reg.occ[i] + 16'h0001; // [R14]
				end
				set_ua[i] = p_nz[i]; // [R14]
			end
			// simultaneous events: the highest index is kept
			if (ev_pu[i] || ev_do[i]) begin
				r_next.hist = {r_reg.secs[SAM_DW-SAM_HIST_SEC-1:0], 4'h0,
				               1'b1, ev_do[i], SAM_AIW'(i)}; // [R14]
			end
		end
		// configuration writes
		if (wr && in_alm) begin
			case (sub)
				SAM_S_CFG: begin
					r_next.en[ai]    = PWDATA_I[SAM_CFG_EN];
					r_next.under[ai] = PWDATA_I[SAM_CFG_UNDER];
					r_next.prio[ai]  = PWDATA_I[SAM_CFG_PRIO +: 2]; // [R7]
					r_next.dsel[ai]  = PWDATA_I[SAM_CFG_DOUT +: 2]; // [R8]
				end
				SAM_S_PU:  r_next.pu[ai]  = PWDATA_I;
				SAM_S_DO:  r_next.dr[ai]  = PWDATA_I;
				SAM_S_PUD: r_next.pud[ai] = wdly; // [R4]
				SAM_S_DOD: r_next.dod[ai] = wdly; // [R6]
				default:   r_next.pu[ai]  = r_reg.pu[ai];
			endcase
		end
		if (wr && PADDR_I == SAM_A_IRQ_EN) begin
			r_next.irq_en = PWDATA_I[2*SAM_NA-1:0];
		end
		if (wr && PADDR_I == SAM_A_LED) begin
			r_next.led_alarm = PWDATA_I[0]; // [R10]
		end
		// sticky bits: a new event wins over a clear in the same cycle
		r_next.status = (r_reg.status
		    & ~((wr && PADDR_I == SAM_A_IRQ_CLR)
		        ? PWDATA_I[2*SAM_NA-1:0] : '0)) | {ev_do, ev_pu};
		r_next.unack = (r_reg.unack
		    & ~((wr && PADDR_I == SAM_A_ACK)
		        ? PWDATA_I[SAM_NA-1:0] : '0)) | set_ua; // [R12]
		// outputs follow the next alarm state so they move with it
		r_next.dout1 = |(r_next.active & sel1); // [R8]
		r_next.dout2 = |(r_next.active & sel2); // [R8]
		r_next.ind   = |(r_next.active & p_nz) // [R11] [R16]
		             | |(r_next.unack & p_hi); // [R12]
		r_next.led   = (r_reg.led_alarm && !LED_FIXED_ENERGY)
		             ? (|r_next.active & r_reg.blink) // [R9] [R10]
		             : ENERGY_PULSE_I;
		r_next.irq   = |(r_next.status & r_reg.irq_en);
		// read data is captured in the setup phase: zero wait states
		if (PSEL_I && !PENABLE_I) begin
			r_next.prdata  = rd;
			r_next.pslverr = ~mapped;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			r_reg <= SAM_STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign PRDATA_O             = r_reg.prdata;
	assign PREADY_O             = 1'b1;
	assign PSLVERR_O            = r_reg.pslverr & PSEL_I & PENABLE_I;
	assign DIGITAL_OUTPUT_ONE_O = r_reg.dout1;
	assign DIGITAL_OUTPUT_TWO_O = r_reg.dout2;
	assign ALARM_ACTIVE_O       = r_reg.ind;
	assign LED_O                = r_reg.led;
	assign IRQ_O                = r_reg.irq;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	property p_dis;
		!r_reg.en[0] |=> !r_reg.active[0];
	endproperty
	a_dis: assert property (p_dis) else $error("disabled alarm active"); // [R1]
	property p_over;
		r_reg.en[0] && !r_reg.under[0] && !r_reg.active[0]
		&& r_reg.pud[0] == '0 && VALUE_I[31:0] > r_reg.pu[0]
		|=> r_reg.active[0];
	endproperty
	a_over: assert property (p_over) else $error("over no trip"); // [R2]
	property p_under;
		r_reg.en[0] && r_reg.under[0] && !r_reg.active[0]
		&& r_reg.pud[0] == '0 && VALUE_I[31:0] < r_reg.pu[0]
		|=> r_reg.active[0];
	endproperty
	a_under: assert property (p_under) else $error("under no trip"); // [R3]
	property p_rise;
		$rose(r_reg.active[0]) |-> $past(pu_cond[0])
		    && $past(r_reg.cnt[0]) >= $past(r_reg.pud[0]);
	endproperty
	a_rise: assert property (p_rise) else $error("early trip"); // [R4]
	property p_fall;
		$fell(r_reg.active[0]) && $past(r_reg.en[0])
		|-> $past(do_cond[0]);
	endproperty
	a_fall: assert property (p_fall) else $error("bad dropout"); // [R6]
	property p_dout;
		##1 DIGITAL_OUTPUT_ONE_O == |(r_reg.active & $past(sel1));
	endproperty
	a_dout: assert property (p_dout) else $error("output one wrong"); // [R8]
	property p_ind;
		$rose(r_reg.active[0]) && $past(p_nz[0]) |-> ALARM_ACTIVE_O;
	endproperty
	a_ind: assert property (p_ind) else $error("no indication"); // [R11]
	// an ack written in the same cycle may release the indication
	property p_hold;
		r_reg.unack[0] && p_hi[0]
		&& !(wr && PADDR_I == SAM_A_ACK && PWDATA_I[0])
		|=> ALARM_ACTIVE_O;
	endproperty
	a_hold: assert property (p_hold) else $error("high not held"); // [R12]
	property p_occ;
		$rose(r_reg.active[0]) && $past(r_reg.occ[0]) != 16'hFFFF
		|-> r_reg.occ[0] == $past(r_reg.occ[0]) + 16'h0001;
	endproperty
	a_occ: assert property (p_occ) else $error("count missed"); // [R14]
	property p_led;
		r_reg.led_alarm && !LED_FIXED_ENERGY && r_next.active == '0
		|=> !LED_O;
	endproperty
	a_led: assert property (p_led) else $error("led lit idle"); // [R9]
	property p_drop;
		r_reg.en[0] && !r_reg.under[0] && r_reg.active[0]
		&& r_reg.dod[0] == '0 && VALUE_I[31:0] < r_reg.dr[0]
		|=> !r_reg.active[0];
	endproperty
	a_drop: assert property (p_drop) else $error("no dropout"); // [R5]
	property p_evt;
		$rose(r_reg.active[0]) && $past(r_reg.en[0])
		|-> r_reg.status[0] && r_reg.hist[SAM_HIST_VAL];
	endproperty
	a_evt: assert property (p_evt) else $error("no record"); // [R14]
	// energy mode passes the pulse through one register stage
	property p_mode;
		!r_reg.led_alarm |=> LED_O == $past(ENERGY_PULSE_I);
	endproperty
	a_mode: assert property (p_mode) else $error("led mode"); // [R10]
	// with no unacked high alarm the indication follows the active alarms of nonzero priority
	property p_quiet;
		r_reg.active != '0 && r_next.active == '0
		&& (r_reg.unack & p_hi) == '0 |=> !ALARM_ACTIVE_O;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stuck ind"); // [R16]
	c_trip: cover property ($rose(r_reg.active[0]));
	c_drop: cover property ($fell(r_reg.active[0]) && r_reg.en[0]);
	c_irq:  cover property ($rose(IRQ_O));
	c_held: cover property (ALARM_ACTIVE_O && r_reg.active == '0);
	c_ack:  cover property (wr && PADDR_I == SAM_A_ACK && r_reg.unack != '0);
endmodule : sam_top

// [tb_top.sv]
// tb_top: self-checking bench for sam_top, driven over APB with seeded
// random setpoints; assumes a short one-second tick for quick runs.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
	err_total++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
	import sam_pkg::*;
	// short tick keeps every delay test to a few dozen cycles
	localparam int TK    = 10;
	localparam int O_D1  = 0;
	localparam int O_D2  = 1;
	localparam int O_ACT = 2;
	localparam int O_LED = 3;
	localparam int O_IRQ = 4;
	logic                     clk, rstn, psel, penable, pwrite, energy;
	logic [SAM_AW-1:0]        paddr;
	logic [SAM_DW-1:0]        pwdata, prdata, rd, pu, dr;
	logic                     pready, pslverr, er;
	logic [SAM_NA*SAM_DW-1:0] value;
	logic                     dout1, dout2, alarm_act, led, irq;
	logic [1:0]               kk;
	logic                     led_prev;
	wire  logic [4:0]         outs;
	int                       err_total, comparisons, occ0, tog;
	assign outs = {irq, led, alarm_act, dout2, dout1};

	sam_top #(.TICK_CYCLES(TK), .LED_FIXED_ENERGY(1'b0)) sam_top_i (
		.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.VALUE_I(value), .ENERGY_PULSE_I(energy),
		.DIGITAL_OUTPUT_ONE_O(dout1), .DIGITAL_OUTPUT_TWO_O(dout2),
		.ALARM_ACTIVE_O(alarm_act), .LED_O(led), .IRQ_O(irq));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic apb(input logic w, input logic [SAM_AW-1:0] a,
			input logic [SAM_DW-1:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			$display("[ERR] pready exp 1 got %b", pready);
			print_verdict();
		end
	endtask : apb

	task automatic wr(input logic [SAM_AW-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [SAM_AW-1:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("prdata", ex, rd)
		`CHK("pslverr", 1'b0, er)
	endtask : rdc

	task automatic setv(input int i, input logic [31:0] v);
		@(posedge clk);
		value[32*i +: 32] <= v;
	endtask : setv

	// output must hold exp for n settled samples
	task automatic hold(input int idx, input logic ex, input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			`CHK("hold", ex, outs[idx])
		end
	endtask : hold

	task automatic wait_bit(input int idx, input logic ex, input int max);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (outs[idx] !== ex && n < max);
		`CHK("wait", ex, outs[idx])
		if (outs[idx] !== ex) print_verdict();
	endtask : wait_bit

	function automatic logic [SAM_AW-1:0] aa(input int i, input logic [4:0] s);
		return SAM_A_ALM_BASE + SAM_AW'(i << SAM_A_STR_SH) + SAM_AW'(s);
	endfunction : aa

	function automatic logic [31:0] cfgw(input logic en, input logic un,
			input logic [1:0] pr, input logic [1:0] ds);
		return {26'h000_0000, ds, pr, un, en};
	endfunction : cfgw

	initial begin
		{rstn, psel, penable, pwrite, energy} = 5'h00;
		paddr = '0;
		pwdata = '0;
		value = '0;
		err_total = 0;
		comparisons = 0;
		occ0 = 0;
		void'($urandom(61680));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("outs", 5'h00, outs)
		rdc(SAM_A_STATUS, 32'h0000_0000);
		apb(1'b0, 12'h024, 32'h0000_0000);
		`CHK("unmapped", 33'h1_0000_0000, {er, rd})
		// every priority and output selection, boundary values included
		for (int k = 0; k < 4; k++) begin
			kk = 2'(k);
			// park low so a fresh random setpoint cannot trip early
			setv(0, 32'h0000_0000);
			pu = $urandom_range(32'h7FFF_FFFF, 32'h0000_1000);
			dr = pu - 32'h0000_0100;
			wr(aa(0, SAM_S_PU), pu);
			wr(aa(0, SAM_S_DO), dr);
			wr(aa(0, SAM_S_CFG), cfgw(1'b1, 1'b0, kk, kk));
			rdc(aa(0, SAM_S_CFG), cfgw(1'b1, 1'b0, kk, kk));
			setv(0, pu);
			hold(O_D1, 1'b0, 4);
			setv(0, pu + 32'h1 + ($urandom() & 32'h0000_00FF));
			repeat (4) @(posedge clk);
			#1;
			`CHK("dout", {kk != 2'h0, kk}, outs[2:0])
			occ0++;
			rdc(aa(0, SAM_S_OCC), 32'(occ0));
			rdc(SAM_A_ACTIVE, 32'h0000_0001);
			setv(0, dr);
			hold(O_D2, kk[1], 4);
			setv(0, dr - 32'h1);
			repeat (4) @(posedge clk);
			#1;
			`CHK("drop", {kk == 2'h3, 2'h0}, outs[2:0])
			rdc(SAM_A_ACTIVE, 32'h0000_0000);
		end
		rdc(SAM_A_UNACK, 32'h0000_0001);
		wr(SAM_A_ACK, 32'h0000_0001);
		wait_bit(O_ACT, 1'b0, 4);
		rdc(SAM_A_UNACK, 32'h0000_0000);
		// under alarm with delays; a break in the condition restarts
		setv(1, 32'h0000_03E8);
		wr(aa(1, SAM_S_PU), 32'h0000_01F4);
		wr(aa(1, SAM_S_DO), 32'h0000_0258);
		wr(aa(1, SAM_S_PUD), 32'h0000_0003);
		wr(aa(1, SAM_S_DOD), 32'h0000_0002);
		wr(aa(1, SAM_S_CFG), cfgw(1'b1, 1'b1, SAM_PRIO_MED, 2'h0));
		setv(1, 32'h0000_01F3);
		hold(O_ACT, 1'b0, 15);
		setv(1, 32'h0000_01F4);
		setv(1, 32'h0000_0064);
		hold(O_ACT, 1'b0, 15);
		wait_bit(O_ACT, 1'b1, 30);
		setv(1, 32'h0000_0258);
		hold(O_ACT, 1'b1, 12);
		setv(1, 32'h0000_0259);
		hold(O_ACT, 1'b1, 8);
		wait_bit(O_ACT, 1'b0, 30);
		apb(1'b0, SAM_A_HIST, 32'h0000_0000);
		`CHK("hist", 8'h0D, rd[7:0])
		// disabled alarm leaves no trace
		wr(SAM_A_IRQ_CLR, 32'h0000_00FF);
		wr(aa(2, SAM_S_PU), 32'h0000_000A);
		wr(aa(2, SAM_S_CFG), cfgw(1'b0, 1'b0, SAM_PRIO_HIGH, 2'h3));
		setv(2, 32'h0000_03E8);
		hold(O_D1, 1'b0, 6);
		`CHK("disabled", 5'h00, outs)
		rdc(SAM_A_STATUS, 32'h0000_0000);
		wr(aa(3, SAM_S_PUD), 32'hFFFF_FFFF);
		rdc(aa(3, SAM_S_PUD), 32'(SAM_DLY_MAX));
		// interrupt masked, enabled, cleared
		wr(SAM_A_IRQ_EN, 32'h0000_0000);
		setv(0, pu + 32'h1);
		hold(O_IRQ, 1'b0, 4);
		rdc(SAM_A_STATUS, 32'h0000_0001);
		apb(1'b0, SAM_A_HIST, 32'h0000_0000);
		`CHK("hist", 8'h08, rd[7:0])
		wr(SAM_A_IRQ_EN, 32'h0000_0001);
		wait_bit(O_IRQ, 1'b1, 4);
		wr(SAM_A_IRQ_CLR, 32'h0000_0001);
		wait_bit(O_IRQ, 1'b0, 4);
		// led blinks in alarm mode, follows pulses in energy mode
		wr(SAM_A_LED, 32'h0000_0001);
		tog = 0;
		led_prev = led;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (led !== led_prev) tog++;
			led_prev = led;
		end
		`CHK("blink", 1'b1, tog >= 4)
		wr(SAM_A_LED, 32'h0000_0000);
		@(posedge clk);
		energy <= 1'b1;
		wait_bit(O_LED, 1'b1, 4);
		@(posedge clk);
		energy <= 1'b0;
		wait_bit(O_LED, 1'b0, 4);
		apb(1'b0, SAM_A_SECONDS, 32'h0000_0000);
		`CHK("seconds", 1'b1, rd != 32'h0000_0000)
		print_verdict();
	end
endmodule : tb_top
